// ==== rtl/smpm_pad_mux.sv ====
// Pad-function multiplexer for the serial multichannel module's pins
// Overview of operation
// - Outside assertion of slave-select pad forces the synchronous controller into slave.
// - Chip select 0 drives slave-select pad in master; selects 1-3 own pads.
// - MISO pad is data input in master, data output in slave.
// - MOSI pad is data output in master, data input in slave.
// - Clock pad driven by device in master, received in slave.
// - Unused synchronous serial pads may serve as general-purpose I/O.
// - While transmission enabled, clock pad never acts as general-purpose I/O.
// - Transmit pads carry channel output; GPIO output only when transmit enable is 0.
// - Receive pads feed channels; GPIO input only when receive enable is 0.
// - External baud clock pad is usable by both async channels.
`timescale 1ns/10ps
module smpm_pad_mux
  import smpm_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire logic                    clk_en,
  // Synchronous serial controller side
  input  wire smpm_spi_out_t           spi_out,
  output smpm_spi_in_t                 spi_in,
  input  wire logic [6:0]              spi_gpio_sel,
  input  wire logic [6:0]              gpio_out,
  input  wire logic [6:0]              gpio_dir,
  output logic      [6:0]              gpio_in,
  // Synchronous serial pads, three signals each
  input  wire logic [6:0]              spi_pad_i,
  output logic      [6:0]              spi_pad_o,
  output logic      [6:0]              spi_pad_oe,
  // Async serial channels
  input  wire logic [1:0]              asc_txd,
  input  wire logic [1:0]              asc_tx_en,
  input  wire logic [1:0]              asc_rx_en,
  input  wire logic [1:0]              asc_gpo,
  output logic      [1:0]              asc_rxd,
  output logic      [1:0]              asc_gpi,
  output logic                         asc_baud_clk,
  // Async serial pads
  output logic      [1:0]              txd_pad_o,
  input  wire logic [1:0]              rxd_pad_i,
  input  wire logic                    baud_clk_pad_i
);

  logic                 rst_meta_q;
  logic                 rst_sync_q;
  logic                 rstn_int;
  logic [6:0]           own;
  logic                 slave;
  smpm_pad_drv_t        drv;

  // Reset release through two flops so release is clean to core_clk
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= SMPM_BIT_RST;
      rst_sync_q <= SMPM_BIT_RST;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rstn_int = rst_sync_q;

  // Slave when controller is not master, or outside party holds select low
  // while the device is not driving it; a master cannot seize a select line
  // that a peripheral already asserts, so no contention on the pad
  assign slave = !spi_out.master
              || (own[SMPM_PAD_PCS0]
                  && !spi_pad_oe[SMPM_PAD_PCS0]
                  && !spi_pad_i[SMPM_PAD_PCS0]);

  // Pad ownership: clock pad held by the serial function during transmit
  always_comb begin
    own = ~spi_gpio_sel;
    if (spi_out.tx_en) begin
      own[SMPM_PAD_SCK] = 1'b1;
    end
  end

  // Pad drive: serial functions where owned, GPIO elsewhere
  always_comb begin
    drv.o  = gpio_out;
    drv.oe = gpio_dir;
    if (own[SMPM_PAD_PCS0]) begin
      drv.o[SMPM_PAD_PCS0]  = spi_out.pcs[0];
      drv.oe[SMPM_PAD_PCS0] = !slave;
    end
    for (int i = 1; i < SMPM_NUM_PCS; i++) begin
      if (own[i]) begin
        drv.o[i]  = spi_out.pcs[i];
        drv.oe[i] = !slave;
      end
    end
    if (own[SMPM_PAD_MISO]) begin
      drv.o[SMPM_PAD_MISO]  = spi_out.sdo;
      drv.oe[SMPM_PAD_MISO] = slave;
    end
    if (own[SMPM_PAD_MOSI]) begin
      drv.o[SMPM_PAD_MOSI]  = spi_out.sdo;
      drv.oe[SMPM_PAD_MOSI] = !slave;
    end
    if (own[SMPM_PAD_SCK]) begin
      drv.o[SMPM_PAD_SCK]  = spi_out.sck;
      drv.oe[SMPM_PAD_SCK] = !slave;
    end
  end

  // Synchronous pads registered; GPIO writes reach pad only when not owned
  always_ff @(posedge core_clk or negedge rstn_int) begin
    if (!rstn_int) begin
      spi_pad_o  <= SMPM_GPIO_RST;
      spi_pad_oe <= SMPM_GPIO_RST; // All pads inputs in reset
    end else if (clk_en) begin
      spi_pad_o  <= drv.o;
      spi_pad_oe <= drv.oe;
    end
  end

  // Controller inputs and GPIO reads; GPIO read always sees the pad
  always_ff @(posedge core_clk or negedge rstn_int) begin
    if (!rstn_int) begin
      spi_in  <= '0;
      gpio_in <= SMPM_GPIO_RST;
    end else if (clk_en) begin
      spi_in.slave <= slave;
      spi_in.sdi   <= slave ? spi_pad_i[SMPM_PAD_MOSI] : spi_pad_i[SMPM_PAD_MISO];
      spi_in.sck   <= spi_pad_i[SMPM_PAD_SCK];
      gpio_in      <= spi_pad_i;
    end
  end

  // Async channels: transmit pad is GPO only with transmit enable clear
  always_ff @(posedge core_clk or negedge rstn_int) begin
    if (!rstn_int) begin
      txd_pad_o <= SMPM_ASC_RST;
    end else if (clk_en) begin
      for (int c = 0; c < SMPM_NUM_ASC; c++) begin
        txd_pad_o[c] <= asc_tx_en[c] ? asc_txd[c] : asc_gpo[c];
      end
    end
  end

  // Receive pads feed channels; GPI reads zero while channel owns the pad
  always_ff @(posedge core_clk or negedge rstn_int) begin
    if (!rstn_int) begin
      asc_rxd      <= SMPM_ASC_RST;
      asc_gpi      <= SMPM_ASC_RST;
      asc_baud_clk <= SMPM_BIT_RST;
    end else if (clk_en) begin
      asc_rxd      <= rxd_pad_i;
      asc_gpi      <= rxd_pad_i & ~asc_rx_en;
      asc_baud_clk <= baud_clk_pad_i;
    end
  end

  // Checks
  property p_tx_own;
    @(posedge core_clk) disable iff (!rstn_int)
      (clk_en && asc_tx_en[0]) |=> (txd_pad_o[0] == $past(asc_txd[0]));
  endproperty
  a_tx_own: assert property (p_tx_own) else $error("tx pad not owned");

  property p_rx_gpi;
    @(posedge core_clk) disable iff (!rstn_int)
      (clk_en && asc_rx_en[1]) |=> (asc_gpi[1] == 1'b0);
  endproperty
  a_rx_gpi: assert property (p_rx_gpi) else $error("rx pad read as gpi");

  property p_sck_tx;
    @(posedge core_clk) disable iff (!rstn_int)
      (clk_en && spi_out.tx_en && spi_out.master && !slave) |=> spi_pad_oe[SMPM_PAD_SCK];
  endproperty
  a_sck_tx: assert property (p_sck_tx) else $error("sck pad not driven in transmit");

  property p_miso_slave;
    @(posedge core_clk) disable iff (!rstn_int)
      (clk_en && !spi_out.master && !spi_gpio_sel[SMPM_PAD_MISO])
        |=> spi_pad_oe[SMPM_PAD_MISO];
  endproperty
  a_miso_slave: assert property (p_miso_slave) else $error("miso not driven in slave");

  property p_mosi_master;
    @(posedge core_clk) disable iff (!rstn_int)
      (clk_en && spi_out.master && !slave && !spi_gpio_sel[SMPM_PAD_MOSI])
        |=> (spi_pad_oe[SMPM_PAD_MOSI] && spi_pad_o[SMPM_PAD_MOSI] == $past(spi_out.sdo));
  endproperty
  a_mosi_master: assert property (p_mosi_master) else $error("mosi wrong in master");

  property p_gpio_read;
    @(posedge core_clk) disable iff (!rstn_int)
      clk_en |=> (gpio_in == $past(spi_pad_i));
  endproperty
  a_gpio_read: assert property (p_gpio_read) else $error("gpio read not pad level");

  property p_baud;
    @(posedge core_clk) disable iff (!rstn_int)
      clk_en |=> (asc_baud_clk == $past(baud_clk_pad_i));
  endproperty
  a_baud: assert property (p_baud) else $error("baud clock not passed");

  property p_gpio_free;
    @(posedge core_clk) disable iff (!rstn_int)
      (clk_en && spi_gpio_sel[1]) |=> (spi_pad_o[1] == $past(gpio_out[1]));
  endproperty
  a_gpio_free: assert property (p_gpio_free) else $error("gpio pad not following gpio");

  property p_ss_forced;
    @(posedge core_clk) disable iff (!rstn_int)
      (clk_en && own[SMPM_PAD_PCS0] && !spi_pad_oe[SMPM_PAD_PCS0] && !spi_pad_i[SMPM_PAD_PCS0])
        |=> (spi_in.slave && !spi_pad_oe[SMPM_PAD_PCS0]);
  endproperty
  a_ss_forced: assert property (p_ss_forced) else $error("select pad did not force slave");

  property p_pcs_master;
    @(posedge core_clk) disable iff (!rstn_int)
      (clk_en && !slave && own[1])
        |=> (spi_pad_oe[1] && spi_pad_o[1] == $past(spi_out.pcs[1]));
  endproperty
  a_pcs_master: assert property (p_pcs_master) else $error("chip select pad not driven");

  property p_sck_slave;
    @(posedge core_clk) disable iff (!rstn_int)
      (clk_en && slave && own[SMPM_PAD_SCK])
        |=> (!spi_pad_oe[SMPM_PAD_SCK] && spi_in.sck == $past(spi_pad_i[SMPM_PAD_SCK]));
  endproperty
  a_sck_slave: assert property (p_sck_slave) else $error("slave clock not received");

  property p_tx_gpo;
    @(posedge core_clk) disable iff (!rstn_int)
      (clk_en && !asc_tx_en[1]) |=> (txd_pad_o[1] == $past(asc_gpo[1]));
  endproperty
  a_tx_gpo: assert property (p_tx_gpo) else $error("tx pad not following gpo");

endmodule

// ==== rtl/smpm_pkg.sv ====
// Package for the serial module pad multiplexer: widths, reset values, carrier structs
package smpm_pkg;
  localparam int          SMPM_NUM_PCS      = 4;
  localparam int          SMPM_NUM_ASC      = 2;
  localparam int          SMPM_NUM_SPI_PADS = 7;
  localparam logic [6:0]  SMPM_GPIO_RST     = 7'h00;
  localparam logic [1:0]  SMPM_ASC_RST      = 2'h0;
  localparam logic        SMPM_BIT_RST      = 1'b0;
  localparam int          SMPM_PAD_PCS0     = 0;
  localparam int          SMPM_PAD_MISO     = 4;
  localparam int          SMPM_PAD_MOSI     = 5;
  localparam int          SMPM_PAD_SCK      = 6;

  // Synchronous serial controller side of the pads
  typedef struct packed {
    logic       master;   // Controller wants master operation
    logic       tx_en;    // Controller enabled for transmission
    logic [3:0] pcs;      // Peripheral chip selects
    logic       sdo;      // Serial data out of the controller
    logic       sck;      // Clock driven in master operation
  } smpm_spi_out_t;

  typedef struct packed {
    logic slave;  // Slave operation: controller not master, or forced by the slave-select pad
    logic sdi;    // Serial data into the controller
    logic sck;    // Clock received in slave operation
  } smpm_spi_in_t;

  // Two-signal view (output and output enable) of a bank of two-way pads
  typedef struct packed {
    logic [6:0] o;
    logic [6:0] oe;
  } smpm_pad_drv_t;
endpackage

// ==== dv/smpm_periph_model.sv ====
// Far-side peripheral model: resolves the serial pads against the device drive
`timescale 1ns/10ps
module smpm_periph_model (
  input  wire logic       core_clk,
  input  wire logic [6:0] pad_o,
  input  wire logic [6:0] pad_oe,
  input  wire logic [6:0] ext_oe,
  input  wire logic [6:0] ext_val,
  input  wire logic [1:0] line_val,
  input  wire logic       baud_val,
  output logic      [6:0] pad_i,
  output logic      [1:0] rxd,
  output logic            baud
);
  logic [6:0] float_q = 7'h55;
  // Undriven lines toggle so a stale level never passes
  always @(posedge core_clk) float_q <= ~float_q;
  // Select, slave clock and slave data come from the peripheral
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pad_i[i] = pad_oe[i] ? pad_o[i] : (ext_oe[i] ? ext_val[i] : float_q[i]);
    end
  end
  // Transceiver and baud source lines
  assign rxd  = line_val;
  assign baud = baud_val;
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the serial module pad multiplexer
`timescale 1ns/10ps
module tb;
  import smpm_pkg::*;
  smpm_spi_out_t so;
  smpm_spi_in_t  si;
  logic          core_clk, rstn, clk_en, bclk, bpad, bval;
  logic [6:0]    sel, gout, gdir, gin, pi, po, poe, eoe, ev;
  logic [1:0]    txd, ten, ren, gpo, rxd, gpi, tpad, rpad, lv;
  int            fails, num_checks;
  smpm_pad_mux dut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .spi_out(so),
    .spi_in(si), .spi_gpio_sel(sel), .gpio_out(gout), .gpio_dir(gdir), .gpio_in(gin),
    .spi_pad_i(pi), .spi_pad_o(po), .spi_pad_oe(poe), .asc_txd(txd), .asc_tx_en(ten),
    .asc_rx_en(ren), .asc_gpo(gpo), .asc_rxd(rxd), .asc_gpi(gpi), .asc_baud_clk(bclk),
    .txd_pad_o(tpad), .rxd_pad_i(rpad), .baud_clk_pad_i(bpad));
  smpm_periph_model peer (.core_clk(core_clk), .pad_o(po), .pad_oe(poe), .ext_oe(eoe),
    .ext_val(ev), .line_val(lv), .baud_val(bval), .pad_i(pi), .rxd(rpad), .baud(bpad));
  task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Three edges: pads settle and the looped-back input is registered
  task automatic step();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  // Hang guard
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    report_and_stop();
  end
  initial begin
    {rstn, so, sel, gout, gdir, eoe, ev, txd, ten, ren, gpo, lv, bval} = '0;
    clk_en = 1;
    repeat (8) @(posedge core_clk);
    #1 rstn = 1;
    step();
    // Master: owned pads ignore the port bits, miso is an input
    for (int b = 0; b < 2; b++) begin
      so = '{1'b1, 1'b1, b ? 4'hA : 4'h5, b[0], b[0]};
      {sel, gout, gdir, eoe} = {7'h00, 7'h7F, 7'h7F, 7'h10};
      ev = {2'b00, b[0], 4'h0};
      step();
      chk("pad_oe", 7'h6F, poe);
      chk("pad_o", {b[0], b[0], 1'b0, so.pcs}, po & 7'h6F);
      chk("gpio_in", {{3{b[0]}}, so.pcs}, gin);
      chk("sdi", {6'h00, b[0]}, {6'h00, si.sdi});
    end
    // Slave: peripheral drives select low, mosi and clock
    for (int b = 0; b < 2; b++) begin
      so = '{1'b0, 1'b0, 4'hF, b[0], 1'b1};
      {gout, gdir, eoe} = {7'h00, 7'h00, 7'h61};
      ev = {b[0], ~b[0], 5'h00};
      step();
      chk("slave oe", 7'h10, poe);
      chk("miso", {6'h00, b[0]}, {6'h00, po[4]});
      chk("spi_in", {4'h0, 1'b1, ~b[0], b[0]}, {4'h0, si});
    end
    // Master request while the peripheral still holds select low stays slave
    so = '{1'b1, 1'b0, 4'h0, 1'b1, 1'b0};
    step();
    chk("forced oe", 7'h10, poe);
    chk("forced slave", 7'h01, {6'h00, si.slave});
    // Peripheral lets select go high: master takes the pads
    ev[0] = 1'b1;
    step();
    chk("master oe", 7'h6F, poe);
    chk("master slave", 7'h00, {6'h00, si.slave});
    // All pads as port bits
    so = '0;
    {sel, gdir, gout, eoe, ev} = {7'h7F, 7'h0F, 7'h05, 7'h70, 7'h50};
    step();
    chk("gpio oe", 7'h0F, poe);
    chk("gpio o", 7'h05, po & 7'h0F);
    chk("gpio in", 7'h55, gin);
    // Clock pad stays with the controller while transmitting
    so = '{1'b1, 1'b1, 4'h0, 1'b0, 1'b1};
    {gdir, gout} = {7'h40, 7'h00};
    step();
    chk("sck pad", 7'h03, {5'h00, poe[6], po[6]});
    // Frozen while the clock enable is low
    clk_en = 0;
    so.sck = 0;
    step();
    chk("frozen", 7'h03, {5'h00, poe[6], po[6]});
    clk_en = 1;
    // Async channels: each pad in both ownerships
    for (int b = 0; b < 2; b++) begin
      {ten, ren, txd, gpo} = {b[0], ~b[0], ~b[0], b[0], {2{~b[0]}}, {2{b[0]}}};
      lv = {1'b1, ~b[0]};
      bval = ~b[0];
      step();
      chk("asc", {2'b01, lv, lv & ~ren, ~b[0]}, {tpad, rxd, gpi, bclk});
    end
    rstn = 0;
    #1;
    chk("reset oe", 7'h00, poe);
    report_and_stop();
  end
endmodule
